// File: scr_clock_reset_regs.sv
`timescale 1ns/1ps
// Behaviour
// R1 - core cause bit 1 set when last reset was a system reset request
// R2 - core cause bit 2 set when last reset came from the watchdog
// R3 - core cause bit 3 set when last reset came from core lock-up
// R4 - core cause register read-only, resets to zero, other bits read zero
// R5 - identity register read-only: revision, version, product, upper bits zero
// R6 - clock gate bit 1 runs a peripheral clock; all on after reset except 18, 19
// R7 - steering bit n puts the converter on DMA channel n; resets to zero
// R8 - several steering bits together are neither blocked nor corrected
// R9 - radio cause read-only: bit 1 brown-out, bit 2 power-on, resets to 0x5
// R10 - radio cause bits 3 to 7 record wake-up from the five wake pins in order
// R11 - radio cause bit 8 timer one wake, bit 10 timer two wake
// R12 - 9-bit window field in slow periods, writable, resets to fifteen
// R13 - period result counts the window in half periods of the 16 MHz clock
// R14 - entering the second active state starts a measurement over 16 slow periods
// R15 - writing zero to the period result starts a measurement with the window field
// R16 - frequency result register at 0x14, read-only, resets to zero
// R17 - measurement event register at 0x18, resets to zero
// R18 - frequency result equals 239 divided by the period result, upper bits zero
// R19 - event bit 0 reads pending; writing 1 clears it, writing 0 does nothing
// R20 - software writes reserved fields with their reset values
// R21 - pending flag set when results update at window end, held until cleared
module scr_clock_reset_regs
  import scr_pkg::*;
#(
  // arbitrary identity values
  parameter logic [3:0] ID_REVISION = 4'h3,
  parameter logic [3:0] ID_VERSION = 4'h2,
  parameter logic [3:0] ID_PRODUCT = 4'h4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_grp_radio,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cause_sys_request,
  input wire logic i_cause_watchdog,
  input wire logic i_cause_lockup,
  input wire logic i_wake_event,
  input wire logic i_cause_brownout,
  input wire logic i_cause_poweron,
  input wire logic [PIN_WAKE_COUNT-1:0] i_pin_wake,
  input wire logic i_radio_timer_one_wake,
  input wire logic i_radio_timer_two_wake,
  input wire logic i_second_active,
  input wire logic i_slow_clk,
  output logic [31:0] o_rdata,
  output logic [31:0] o_periph_clk_en,
  output logic [DMA_CH_COUNT-1:0] o_converter_dma_sel,
  output logic o_meas_done_pending,
  output logic o_meas_busy
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_core;
  logic wr_radio;
  logic rel_q;
  logic [31:0] core_cause_q;
  logic [31:0] clk_gate_q;
  logic [DMA_CH_COUNT-1:0] dma_sel_q;
  logic [31:0] radio_cause_q;
  logic [WINDOW_W-1:0] window_field_q;
  logic [PERIOD_W-1:0] period_q;
  logic [FREQ_W-1:0] freq_q;
  logic pending_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic sw_start;
  logic auto_start;
  logic meas_done;
  logic ev_clear;

  assign wr_core = i_wr && !i_grp_radio;
  assign wr_radio = i_wr && i_grp_radio;
  assign sw_start = wr_radio && i_addr == SLOW_MEAS_PERIOD_OFS && i_wdata == 32'h0000_0000; // R15
  assign auto_start = i_second_active; // R14
  assign ev_clear = wr_radio && i_addr == SLOW_MEAS_EVENT_OFS
                    && i_wdata[MEAS_DONE_PENDING_BIT]; // R19

  // ----------------------------------------------------------------
  // reset causes
  // ----------------------------------------------------------------
  // causes are caught on the first edge after release, never under reset
  always_ff @(posedge i_clk) begin
    rel_q <= i_srst;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      core_cause_q <= CORE_RESET_CAUSE_RST; // R4
    end else if (rel_q) begin
      core_cause_q <= CORE_RESET_CAUSE_RST;
      core_cause_q[SYS_REQUEST_CAUSE_BIT] <= i_cause_sys_request; // R1
      core_cause_q[WATCHDOG_CAUSE_BIT] <= i_cause_watchdog; // R2
      core_cause_q[LOCKUP_CAUSE_BIT] <= i_cause_lockup; // R3
    end
  end

  // radio group causes are written only by the wake controller event
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      radio_cause_q <= RADIO_RESET_WAKE_RST; // R9
    end else if (i_wake_event) begin
      radio_cause_q <= RADIO_RESET_WAKE_RST;
      radio_cause_q[BROWNOUT_CAUSE_BIT] <= i_cause_brownout; // R9
      radio_cause_q[POWERON_CAUSE_BIT] <= i_cause_poweron; // R9
      radio_cause_q[PIN_WAKE_FIRST_BIT +: PIN_WAKE_COUNT] <= i_pin_wake; // R10
      radio_cause_q[RADIO_TIMER_ONE_WAKE_BIT] <= i_radio_timer_one_wake; // R11
      radio_cause_q[RADIO_TIMER_TWO_WAKE_BIT] <= i_radio_timer_two_wake; // R11
    end
  end

  // ----------------------------------------------------------------
  // writable control
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clk_gate_q <= PERIPH_CLOCK_GATE_RST; // R6
    end else if (wr_core && i_addr == PERIPH_CLOCK_GATE_OFS) begin
      clk_gate_q <= i_wdata; // R6
    end
  end

  // no one-hot check: software owns the single-channel choice
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dma_sel_q <= DMA_STEERING_RST; // R7
    end else if (wr_core && i_addr == DMA_STEERING_OFS) begin
      dma_sel_q <= i_wdata[DMA_CH_COUNT-1:0]; // R8
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      window_field_q <= SLOW_MEAS_WINDOW_RST; // R12
    end else if (wr_radio && i_addr == SLOW_MEAS_WINDOW_OFS) begin
      window_field_q <= i_wdata[WINDOW_W-1:0]; // R12
    end
  end

  assign o_periph_clk_en = clk_gate_q;
  assign o_converter_dma_sel = dma_sel_q; // R7

  // ----------------------------------------------------------------
  // slow clock input
  // ----------------------------------------------------------------
  logic [2:0] slow_sync_q;
  logic slow_rise;

  // no reset on these stages: cleared stages would fake a slow edge after release
  always_ff @(posedge i_clk) begin
    slow_sync_q <= {slow_sync_q[1:0], i_slow_clk};
  end

  // only stages two and three are looked at
  assign slow_rise = slow_sync_q[1] && !slow_sync_q[2];

  // ----------------------------------------------------------------
  // slow clock measurement
  // ----------------------------------------------------------------
  scr_meas_state_type state_q;
  logic [WINDOW_W-1:0] win_q;
  logic [WINDOW_W-1:0] edges_q;
  logic [PERIOD_W+3:0] cycles_q;
  logic [PERIOD_W-1:0] period_d;
  logic [FREQ_W-1:0] freq_d;
  logic [PERIOD_W+9:0] scaled;

  // a new start always restarts, even mid-window
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= MEAS_IDLE;
      win_q <= SLOW_MEAS_WINDOW_RST;
    end else if (auto_start) begin
      state_q <= MEAS_ARM;
      win_q <= AUTO_WINDOW; // R14
    end else if (sw_start) begin
      state_q <= MEAS_ARM;
      win_q <= window_field_q; // R15
    end else begin
      unique case (state_q)
        MEAS_IDLE: state_q <= MEAS_IDLE;
        MEAS_ARM: if (slow_rise) begin
          state_q <= MEAS_RUN;
        end
        MEAS_RUN: if (meas_done) begin
          state_q <= MEAS_IDLE;
        end
      endcase
    end
  end

  assign meas_done = state_q == MEAS_RUN && slow_rise && edges_q + 9'h001 >= win_q;

  always_ff @(posedge i_clk) begin
    if (i_srst || state_q != MEAS_RUN || auto_start || sw_start) begin
      edges_q <= 9'h000;
      cycles_q <= '0;
    end else begin
      cycles_q <= cycles_q + 23'h00_0001;
      if (slow_rise) begin
        edges_q <= edges_q + 9'h001;
      end
    end
  end

  // 10 MHz cycles converted to 32 MHz ticks; truncation loses under one tick
  always_comb begin
    scaled = (29'(cycles_q) + 29'h000_0001) * 29'(HALF_TICK_NUM) / 29'(HALF_TICK_DEN);
    period_d = scaled[PERIOD_W-1:0]; // R13
    freq_d = (period_d == 19'h0_0000) ? FREQ_RESULT_RST
             : FREQ_W'(FREQ_CONSTANT / 27'(period_d)); // R18
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      period_q <= PERIOD_RESULT_RST;
      freq_q <= FREQ_RESULT_RST; // R16
    end else if (meas_done) begin
      period_q <= period_d; // R13
      freq_q <= freq_d; // R18
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pending_q <= 1'b0; // R17
    end else if (meas_done) begin
      pending_q <= 1'b1; // R21
    end else if (ev_clear) begin
      pending_q <= 1'b0; // R19
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_meas_busy <= 1'b0;
      o_meas_done_pending <= 1'b0;
    end else begin
      o_meas_busy <= state_q != MEAS_IDLE || auto_start || sw_start;
      o_meas_done_pending <= meas_done || (pending_q && !ev_clear);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!i_grp_radio) begin
      unique case (i_addr)
        CORE_RESET_CAUSE_OFS: rdata_d = core_cause_q; // R4
        DIE_IDENTITY_OFS: begin
          rdata_d[ID_REV_LSB +: 4] = ID_REVISION; // R5
          rdata_d[ID_VERSION_LSB +: 4] = ID_VERSION;
          rdata_d[ID_PRODUCT_LSB +: 4] = ID_PRODUCT;
        end
        PERIPH_CLOCK_GATE_OFS: rdata_d = clk_gate_q;
        DMA_STEERING_OFS: rdata_d[DMA_CH_COUNT-1:0] = dma_sel_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end else begin
      unique case (i_addr)
        RADIO_RESET_WAKE_OFS: rdata_d = radio_cause_q; // R9
        SLOW_MEAS_WINDOW_OFS: rdata_d[WINDOW_W-1:0] = window_field_q;
        SLOW_MEAS_PERIOD_OFS: rdata_d[PERIOD_W-1:0] = period_q;
        SLOW_MEAS_FREQ_OFS: rdata_d[FREQ_W-1:0] = freq_q; // R16
        SLOW_MEAS_EVENT_OFS: rdata_d[MEAS_DONE_PENDING_BIT] = pending_q; // R17
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_start;
    auto_start || sw_start;
  endsequence

  a_core_cause_load: assert property ( // R1
    rel_q |=> core_cause_q[SYS_REQUEST_CAUSE_BIT] == $past(i_cause_sys_request)
      && core_cause_q[WATCHDOG_CAUSE_BIT] == $past(i_cause_watchdog)
      && core_cause_q[LOCKUP_CAUSE_BIT] == $past(i_cause_lockup))
    else $error("core cause not captured after release");

  a_core_cause_reserved: assert property ( // R4
    core_cause_q[0] == 1'b0 && core_cause_q[31:4] == 28'h000_0000)
    else $error("core cause reserved bit set");

  a_radio_pin_wake: assert property ( // R10
    i_wake_event |=> radio_cause_q[7:3] == $past(i_pin_wake)
      && radio_cause_q[0] && radio_cause_q[9] == 1'b0)
    else $error("wake pin causes misplaced");

  a_dma_steer_write: assert property ( // R8
    wr_core && i_addr == DMA_STEERING_OFS |=> o_converter_dma_sel == $past(i_wdata[7:0]))
    else $error("steering write not taken as written");

  a_auto_window_len: assert property ( // R14
    auto_start |=> win_q == AUTO_WINDOW && state_q == MEAS_ARM && o_meas_busy)
    else $error("automatic start window wrong");

  a_sw_start_window: assert property ( // R15
    sw_start && !auto_start |=> win_q == $past(window_field_q) && state_q == MEAS_ARM)
    else $error("software start did not take window field");

  a_result_and_flag: assert property ( // R21
    meas_done |=> pending_q && o_meas_done_pending && period_q == $past(period_d)
      && (state_q == MEAS_IDLE || $past(auto_start || sw_start)))
    else $error("window end did not update results and flag");

  a_freq_quotient: assert property ( // R18
    meas_done && period_d != 19'h0_0000 |=> freq_q * 27'(period_q) <= FREQ_CONSTANT
      && (freq_q + 27'h000_0001) * 27'(period_q) > FREQ_CONSTANT)
    else $error("frequency result is not the quotient");

  a_event_clear: assert property ( // R19
    ev_clear && !meas_done |=> !pending_q ##1 !o_meas_done_pending || pending_q)
    else $error("pending flag not cleared");

  a_event_hold: assert property ( // R21
    pending_q && !ev_clear |=> pending_q)
    else $error("pending flag dropped without clear");

  a_gate_read: assert property ( // R6
    i_rd && !i_grp_radio && i_addr == PERIPH_CLOCK_GATE_OFS |=> o_rdata == $past(clk_gate_q))
    else $error("clock gate readback mismatch");

  a_read_idle_zero: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  a_arm_to_run: assert property ( // R13
    state_q == MEAS_ARM && slow_rise && !auto_start && !sw_start |=> state_q == MEAS_RUN)
    else $error("measurement did not begin on slow edge");

  a_busy_on_start: assert property ( // R15
    s_start |=> o_meas_busy && state_q == MEAS_ARM)
    else $error("start did not arm the measurement");

  a_window_gate_reset: assert property ( // R12
    $fell(i_srst) |-> window_field_q == SLOW_MEAS_WINDOW_RST
      && o_periph_clk_en == PERIPH_CLOCK_GATE_RST)
    else $error("reset values wrong after release");
endmodule // scr_clock_reset_regs

// File: scr_clock_reset_regs_tb_top.sv
`timescale 1ns/1ps
module scr_clock_reset_regs_tb_top;
  import scr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int SLOW_P = 30;  // slow clock period in system cycles, kept short for run time
  logic i_clk = 1'b0, i_srst = 1'b1, i_grp_radio = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_cause_sys_request = 1'b0, i_cause_watchdog = 1'b0, i_cause_lockup = 1'b0;
  logic i_wake_event = 1'b0, i_cause_brownout = 1'b0, i_cause_poweron = 1'b0;
  logic [PIN_WAKE_COUNT-1:0] i_pin_wake = 5'h00;
  logic i_radio_timer_one_wake = 1'b0, i_radio_timer_two_wake = 1'b0;
  logic i_second_active = 1'b0, i_slow_clk = 1'b0;
  logic [31:0] o_rdata, o_periph_clk_en;
  logic [DMA_CH_COUNT-1:0] o_converter_dma_sel;
  logic o_meas_done_pending, o_meas_busy;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] rd_q;
  logic [31:0] exp_q;

  always #50 i_clk = ~i_clk;
  // slow clock free-runs with a phase unrelated to the system clock
  initial begin
    #37;
    forever #(SLOW_P * 50) i_slow_clk = ~i_slow_clk;
  end

  // arbitrary identity values
  scr_clock_reset_regs #(.ID_REVISION(4'h5), .ID_VERSION(4'h6), .ID_PRODUCT(4'h7))
    scr_clock_reset_regs_inst (.i_clk(i_clk), .i_srst(i_srst), .i_grp_radio(i_grp_radio),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_cause_sys_request(i_cause_sys_request), .i_cause_watchdog(i_cause_watchdog),
    .i_cause_lockup(i_cause_lockup), .i_wake_event(i_wake_event),
    .i_cause_brownout(i_cause_brownout), .i_cause_poweron(i_cause_poweron),
    .i_pin_wake(i_pin_wake), .i_radio_timer_one_wake(i_radio_timer_one_wake),
    .i_radio_timer_two_wake(i_radio_timer_two_wake), .i_second_active(i_second_active),
    .i_slow_clk(i_slow_clk), .o_rdata(o_rdata), .o_periph_clk_en(o_periph_clk_en),
    .o_converter_dma_sel(o_converter_dma_sel), .o_meas_done_pending(o_meas_done_pending),
    .o_meas_busy(o_meas_busy));

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic check_range(input logic [31:0] seen, input int lo, input int hi, string msg);
    check({31'h0, (seen >= lo) && (seen <= hi)}, 32'h1, msg);
  endtask

  task automatic wr(input logic grp, input logic [7:0] addr, input logic [31:0] data);
    @(posedge i_clk);
    i_grp_radio <= grp;
    i_addr <= addr;
    i_wdata <= data;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample it right there
  task automatic rd(input logic grp, input logic [7:0] addr, output logic [31:0] data);
    @(posedge i_clk);
    i_grp_radio <= grp;
    i_addr <= addr;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    data = o_rdata;
  endtask

  task automatic rd_check(input logic grp, input logic [7:0] addr, input logic [31:0] exp,
                          input string msg);
    logic [31:0] d;
    rd(grp, addr, d);
    check(d, exp, msg);
  endtask

  task automatic do_reset();
    i_srst <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic wake(input logic bo, input logic po, input logic [4:0] pins, input logic t1,
                      input logic t2);
    @(posedge i_clk);
    i_cause_brownout <= bo;
    i_cause_poweron <= po;
    i_pin_wake <= pins;
    i_radio_timer_one_wake <= t1;
    i_radio_timer_two_wake <= t2;
    i_wake_event <= 1'b1;
    @(posedge i_clk);
    i_wake_event <= 1'b0;
    exp_q = 32'h1 | {31'h0, bo} << 1 | {31'h0, po} << 2 | {27'h0, pins} << 3
            | {31'h0, t1} << 8 | {31'h0, t2} << 10;
  endtask

  // a bounded wait; a hang ends the run as a failure
  task automatic wait_done(input int bound);
    int i;
    bit busy_seen;
    busy_seen = 1'b0;
    for (i = 0; i < bound && o_meas_done_pending !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
      if (o_meas_busy === 1'b1) busy_seen = 1'b1;
    end
    check({31'h0, o_meas_done_pending === 1'b1}, 32'h1, "measurement finished");
    if (o_meas_done_pending !== 1'b1) begin
      conclude();
    end
    check({31'h0, busy_seen}, 32'h1, "busy during measurement");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    // each core cause in turn, then none; a reset loads whatever is pending
    for (k = 1; k <= 4; k++) begin
      if (k > 1) begin
        @(posedge i_clk);
      end
      i_cause_sys_request <= (k == 1);
      i_cause_watchdog <= (k == 2);
      i_cause_lockup <= (k == 3);
      do_reset();
      rd_check(1'b0, 8'h08, (k == 4) ? 32'h0 : (32'h1 << k), "core cause");
    end
    wr(1'b0, 8'h08, 32'h0000_000E);
    rd_check(1'b0, 8'h08, 32'h0000_0000, "core cause write ignored");
    rd_check(1'b0, 8'h1C, 32'h0000_0765, "identity");
    wr(1'b0, 8'h1C, 32'h0000_0000);
    rd_check(1'b0, 8'h1C, 32'h0000_0765, "identity write ignored");
    check(o_periph_clk_en, 32'h0003_FFFF, "gate reset");
    rd_check(1'b0, 8'h20, 32'h0003_FFFF, "gate reset read");
    wr(1'b0, 8'h20, 32'h000C_C060);
    #1;
    check(o_periph_clk_en, 32'h000C_C060, "gate write");
    rd_check(1'b0, 8'h20, 32'h000C_C060, "gate read back");
    check({24'h0, o_converter_dma_sel}, 32'h0, "steering reset");
    for (k = 0; k < 8; k++) begin
      wr(1'b0, 8'h24, 32'h1 << k);
      #1;
      check({24'h0, o_converter_dma_sel}, 32'h1 << k, "steering channel");
    end
    wr(1'b0, 8'h24, 32'h0000_00FF);
    rd_check(1'b0, 8'h24, 32'h0000_00FF, "several channels kept");
    rd_check(1'b0, 8'h04, 32'h0000_0000, "unmapped core read");
    // radio group: reset values first
    rd_check(1'b1, 8'h08, 32'h0000_0005, "radio cause reset");
    rd_check(1'b1, 8'h0C, 32'h0000_000F, "window reset");
    rd_check(1'b1, 8'h10, 32'h0000_0000, "period reset");
    rd_check(1'b1, 8'h14, 32'h0000_0000, "freq reset");
    rd_check(1'b1, 8'h18, 32'h0000_0000, "event reset");
    rd_check(1'b1, 8'h1C, 32'h0000_0000, "unmapped radio read");
    wake(1'b1, 1'b0, 5'h16, 1'b1, 1'b0);
    rd_check(1'b1, 8'h08, exp_q, "wake pins and timer one");
    wake(1'b0, 1'b1, 5'h01, 1'b0, 1'b1);
    wr(1'b1, 8'h08, 32'h0);
    rd_check(1'b1, 8'h08, exp_q, "poweron and timer two");
    wr(1'b1, 8'h14, 32'h0000_1234);
    rd_check(1'b1, 8'h14, 32'h0000_0000, "freq read-only");
    wr(1'b1, 8'h0C, 32'h0000_01FF);
    rd_check(1'b1, 8'h0C, 32'h0000_01FF, "window nine bits");
    // software start over a one-period window
    wr(1'b1, 8'h0C, 32'h0000_0001);
    wr(1'b1, 8'h10, 32'h0000_0005);
    repeat (3 * SLOW_P) @(posedge i_clk);
    #1;
    check({31'h0, o_meas_done_pending}, 32'h0, "nonzero write starts nothing");
    wr(1'b1, 8'h10, 32'h0000_0000);
    wait_done(6 * SLOW_P);
    rd(1'b1, 8'h10, rd_q);
    check_range(rd_q, SLOW_P * 32 / 10 - 4, (SLOW_P + 1) * 32 / 10 + 4, "period one");
    check({31'h0, o_meas_busy}, 32'h0, "idle after window");
    rd_check(1'b1, 8'h14, 239 / (SLOW_P * 32 / 10), "freq one");
    rd_check(1'b1, 8'h18, 32'h0000_0001, "event pending");
    wr(1'b1, 8'h18, 32'h0000_0000);
    rd_check(1'b1, 8'h18, 32'h0000_0001, "zero write keeps pending");
    wr(1'b1, 8'h18, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    #1;
    check({31'h0, o_meas_done_pending}, 32'h0, "pending cleared");
    rd_check(1'b1, 8'h18, 32'h0000_0000, "event cleared");
    // automatic start ignores the window field and uses sixteen periods
    @(posedge i_clk);
    i_second_active <= 1'b1;
    @(posedge i_clk);
    i_second_active <= 1'b0;
    wait_done(20 * SLOW_P);
    rd(1'b1, 8'h10, rd_q);
    check_range(rd_q, 16 * SLOW_P * 32 / 10 - 4, (16 * SLOW_P + 1) * 32 / 10 + 4,
                "period sixteen");
    rd_check(1'b1, 8'h14, 32'h0000_0000, "freq sixteen");
    wr(1'b1, 8'h18, 32'h0000_0001);
    conclude();
  end
endmodule // scr_clock_reset_regs_tb_top

// File: scr_pkg.sv
package scr_pkg;
  // ----------------------------------------------------------------
  // register map: both groups share the low offset space
  // ----------------------------------------------------------------
  localparam logic [7:0] CORE_RESET_CAUSE_OFS = 8'h08;
  localparam logic [7:0] DIE_IDENTITY_OFS = 8'h1C;
  localparam logic [7:0] PERIPH_CLOCK_GATE_OFS = 8'h20;
  localparam logic [7:0] DMA_STEERING_OFS = 8'h24;
  localparam logic [7:0] RADIO_RESET_WAKE_OFS = 8'h08;
  localparam logic [7:0] SLOW_MEAS_WINDOW_OFS = 8'h0C;
  localparam logic [7:0] SLOW_MEAS_PERIOD_OFS = 8'h10;
  localparam logic [7:0] SLOW_MEAS_FREQ_OFS = 8'h14;
  localparam logic [7:0] SLOW_MEAS_EVENT_OFS = 8'h18;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CORE_RESET_CAUSE_RST = 32'h0000_0000;
  localparam logic [31:0] PERIPH_CLOCK_GATE_RST = 32'h0003_FFFF;
  localparam logic [7:0] DMA_STEERING_RST = 8'h00;
  localparam logic [31:0] RADIO_RESET_WAKE_RST = 32'h0000_0005;
  localparam logic [8:0] SLOW_MEAS_WINDOW_RST = 9'h00F;
  localparam logic [18:0] PERIOD_RESULT_RST = 19'h0_0000;
  localparam logic [26:0] FREQ_RESULT_RST = 27'h000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SYS_REQUEST_CAUSE_BIT = 1;
  localparam int WATCHDOG_CAUSE_BIT = 2;
  localparam int LOCKUP_CAUSE_BIT = 3;
  localparam int BROWNOUT_CAUSE_BIT = 1;
  localparam int POWERON_CAUSE_BIT = 2;
  localparam int PIN_WAKE_FIRST_BIT = 3;
  localparam int PIN_WAKE_COUNT = 5;
  localparam int RADIO_TIMER_ONE_WAKE_BIT = 8;
  localparam int RADIO_TIMER_TWO_WAKE_BIT = 10;
  localparam int MEAS_DONE_PENDING_BIT = 0;
  localparam int ID_REV_LSB = 0;
  localparam int ID_VERSION_LSB = 4;
  localparam int ID_PRODUCT_LSB = 8;
  localparam int WINDOW_W = 9;
  localparam int PERIOD_W = 19;
  localparam int FREQ_W = 27;
  localparam int DMA_CH_COUNT = 8;

  // ----------------------------------------------------------------
  // timing and measurement constants
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int FAST_REF_HZ = 16_000_000;
  // result unit is a half period of the fast reference
  localparam int HALF_TICK_NUM = 2 * FAST_REF_HZ / 1_000_000;
  localparam int HALF_TICK_DEN = SYS_CLK_HZ / 1_000_000;
  localparam logic [8:0] AUTO_WINDOW = 9'h010;
  localparam logic [26:0] FREQ_CONSTANT = 27'h000_00EF;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARM,
    MEAS_RUN
  } scr_meas_state_type;
endpackage
